/* pkg/smbext_pkg.sv */
// Constants for the SMBus extension block
// Functional notes
// - Glitch code zero bypasses the filter
// - Code N swallows pulses up to N periods
// - Field width and filter rate are parameters
// - Fast ack off: value applies to next byte
// - Fast ack on: written value acks current byte
// - Bit 6 enables alert response address match
// - Bit 5 enables second address match
// - Clock select: bus/64 or full bus rate
// - Low timeout flag sets, write one clears
// - Zero low timeout value disables detection
// - Bus free flag, read-only, self clearing
// - High/low flag sets, write one clears
// - Bit 0 enables high/low timeout interrupt
// - Master sees bus free after high timeout
// - Second address in upper seven bits
// - High register gives timeout bits 15:8
// - Low register gives timeout bits 7:0
`default_nettype none
package smbext_pkg;
    // ========================================
    // Register byte offsets
    localparam logic [7:0] OFF_FILTER   = 8'h00;
    localparam logic [7:0] OFF_SMB      = 8'h04;
    localparam logic [7:0] OFF_ADDR2    = 8'h08;
    localparam logic [7:0] OFF_SLT_HI   = 8'h0c;
    localparam logic [7:0] OFF_SLT_LO   = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_ACK      = 8'h1c;
    localparam logic [7:0] OFF_LINES    = 8'h20;
    // ========================================
    // Control/status bit positions
    localparam int B_FAST_ACK_ENABLE   = 7;
    localparam int B_ALERT  = 6;
    localparam int B_SECOND = 5;
    localparam int B_TIMEOUT_CLK_SEL = 4;
    localparam int B_SCL_LOW_TIMEOUT_FLAG   = 3;
    localparam int B_FREE   = 2;
    localparam int B_HLF    = 1;
    localparam int B_HLIE   = 0;
    localparam logic [7:0] SMB_CFG_MASK = 8'hf1;
    // Interrupt status bits
    localparam int I_LOW   = 0;
    localparam int I_HL    = 1;
    localparam int I_ACK   = 2;
    localparam int I_MATCH = 3;
    localparam int IRQ_W   = 4;
    // ========================================
    // Reset values and timing
    localparam logic [7:0] RST_REG8   = 8'h00;
    localparam logic [5:0] PRESC_LAST = 6'h3f;
    localparam int         HI_SHIFT   = 9;
    localparam logic [6:0] ALERT_ADDR = 7'h0c;
    localparam logic [1:0] RESP_OKAY  = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* rtl/smbext_top.sv */
// SMBus extension: glitch filter, fast ack, address match, timeouts
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module smbext_top #(
    parameter int FLT_W       = 4,
    parameter bit DOUBLE_RATE = 1'b0,
    parameter int AW          = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               scl_filt,
    output logic               sda_filt,
    input  wire logic          rx_byte_done,
    input  wire logic          addr_valid,
    input  wire logic [7:0]    addr_byte,
    output logic               ack_strobe,
    output logic               ack_nack,
    output logic               alert_match,
    output logic               second_match,
    output logic               bus_idle,
    output logic               irq
);
    localparam int CW = FLT_W + 2;
    localparam logic [CW-1:0] STEP = DOUBLE_RATE ? CW'(2) : CW'(1);

    // ========================================
    // Register bus
    logic          awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic          aw_got_r, w_got_r;
    logic [AW-1:0] awaddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;
    logic [1:0]    bresp_r, rresp_r;
    logic [31:0]   rdata_r;

    wire aw_hs  = awvalid & awready_r;
    wire w_hs   = wvalid & wready_r;
    wire do_wr  = (aw_hs | aw_got_r) & (w_hs | w_got_r) & ~bvalid_r;
    wire b_hs   = bvalid_r & bready;
    wire ar_hs  = arvalid & arready_r;
    wire r_hs   = rvalid_r & rready;
    wire [AW-1:0] wa = aw_hs ? awaddr : awaddr_q;
    wire [31:0]   wd = w_hs ? wdata : wdata_q;
    wire [3:0]    ws = w_hs ? wstrb : wstrb_q;
    wire          wl = do_wr & ws[0];
    wire [7:0]    wb = wd[7:0];

    wire wr_filter = wl && wa == AW'(smbext_pkg::OFF_FILTER);
    wire wr_smb    = wl && wa == AW'(smbext_pkg::OFF_SMB);
    wire wr_addr2  = wl && wa == AW'(smbext_pkg::OFF_ADDR2);
    wire wr_slt_hi = wl && wa == AW'(smbext_pkg::OFF_SLT_HI);
    wire wr_slt_lo = wl && wa == AW'(smbext_pkg::OFF_SLT_LO);
    wire wr_istat  = wl && wa == AW'(smbext_pkg::OFF_IRQ_STAT);
    wire wr_imask  = wl && wa == AW'(smbext_pkg::OFF_IRQ_MASK);
    wire wr_ack    = wl && wa == AW'(smbext_pkg::OFF_ACK);
    wire wa_ok     = wa == AW'(smbext_pkg::OFF_FILTER) || wa == AW'(smbext_pkg::OFF_SMB)
                  || wa == AW'(smbext_pkg::OFF_ADDR2) || wa == AW'(smbext_pkg::OFF_SLT_HI)
                  || wa == AW'(smbext_pkg::OFF_SLT_LO) || wa == AW'(smbext_pkg::OFF_IRQ_STAT)
                  || wa == AW'(smbext_pkg::OFF_IRQ_MASK) || wa == AW'(smbext_pkg::OFF_ACK)
                  || wa == AW'(smbext_pkg::OFF_LINES);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= smbext_pkg::RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            awready_r <= b_hs ? 1'b1 : (aw_hs ? 1'b0 : awready_r);
            wready_r  <= b_hs ? 1'b1 : (w_hs ? 1'b0 : wready_r);
            aw_got_r  <= do_wr ? 1'b0 : (aw_got_r | aw_hs);
            w_got_r   <= do_wr ? 1'b0 : (w_got_r | w_hs);
            bvalid_r  <= do_wr ? 1'b1 : (b_hs ? 1'b0 : bvalid_r);
            if (do_wr)
                bresp_r <= wa_ok ? smbext_pkg::RESP_OKAY : smbext_pkg::RESP_SLVERR;
            if (aw_hs)
                awaddr_q <= awaddr;
            if (w_hs) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
        end
    end

    // ========================================
    // Software registers
    logic [FLT_W-1:0] flt_r;
    logic [7:0]       smb_cfg_r, addr2_r, slt_hi_r, slt_lo_r;
    logic [smbext_pkg::IRQ_W-1:0] istat_r, imask_r, ievt;
    logic scl_low_timeout_flag_r, hlf_r, bus_free_r, ack_bit_r;

    wire fast_en  = smb_cfg_r[smbext_pkg::B_FAST_ACK_ENABLE];
    wire alert_en = smb_cfg_r[smbext_pkg::B_ALERT];
    wire sec_en   = smb_cfg_r[smbext_pkg::B_SECOND];
    wire timeout_clk_sel   = smb_cfg_r[smbext_pkg::B_TIMEOUT_CLK_SEL];
    wire hl_ie    = smb_cfg_r[smbext_pkg::B_HLIE];
    wire [15:0] lt_val = {slt_hi_r, slt_lo_r};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_r     <= '0;
            smb_cfg_r <= smbext_pkg::RST_REG8;
            addr2_r   <= smbext_pkg::RST_REG8;
            slt_hi_r  <= smbext_pkg::RST_REG8;
            slt_lo_r  <= smbext_pkg::RST_REG8;
            imask_r   <= '0;
            ack_bit_r <= 1'b0;
        end else begin
            if (wr_filter)
                flt_r <= wb[FLT_W-1:0];
            if (wr_smb)
                smb_cfg_r <= wb & smbext_pkg::SMB_CFG_MASK;
            if (wr_addr2)
                addr2_r <= {wb[7:1], 1'b0};
            if (wr_slt_hi)
                slt_hi_r <= wb;
            if (wr_slt_lo)
                slt_lo_r <= wb;
            if (wr_imask)
                imask_r <= wb[smbext_pkg::IRQ_W-1:0];
            if (wr_ack)
                ack_bit_r <= wb[0];
        end
    end
    // ========================================
    // Read path
    logic [7:0] rd_val;
    wire  [AW-1:0] ra = araddr;
    wire  ra_ok = ra == AW'(smbext_pkg::OFF_FILTER) || ra == AW'(smbext_pkg::OFF_SMB)
               || ra == AW'(smbext_pkg::OFF_ADDR2) || ra == AW'(smbext_pkg::OFF_SLT_HI)
               || ra == AW'(smbext_pkg::OFF_SLT_LO) || ra == AW'(smbext_pkg::OFF_IRQ_STAT)
               || ra == AW'(smbext_pkg::OFF_IRQ_MASK) || ra == AW'(smbext_pkg::OFF_ACK)
               || ra == AW'(smbext_pkg::OFF_LINES);
    logic ack_pend_r, scl_filt_r, sda_filt_r;

    always_comb begin
        rd_val = 8'h00;
        case (ra[7:0])
            smbext_pkg::OFF_FILTER:   rd_val = 8'(flt_r);
            smbext_pkg::OFF_SMB:      rd_val = {smb_cfg_r[7:4], scl_low_timeout_flag_r, bus_free_r, hlf_r, smb_cfg_r[0]};
            smbext_pkg::OFF_ADDR2:    rd_val = addr2_r;
            smbext_pkg::OFF_SLT_HI:   rd_val = slt_hi_r;
            smbext_pkg::OFF_SLT_LO:   rd_val = slt_lo_r;
            smbext_pkg::OFF_IRQ_STAT: rd_val = 8'(istat_r);
            smbext_pkg::OFF_IRQ_MASK: rd_val = 8'(imask_r);
            smbext_pkg::OFF_ACK:      rd_val = {7'h00, ack_bit_r};
            smbext_pkg::OFF_LINES:    rd_val = {5'h00, ack_pend_r, sda_filt_r, scl_filt_r};
            default:                  rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= smbext_pkg::RESP_OKAY;
        end else begin
            arready_r <= ar_hs ? 1'b0 : (r_hs ? 1'b1 : arready_r);
            rvalid_r  <= ar_hs ? 1'b1 : (r_hs ? 1'b0 : rvalid_r);
            if (ar_hs) begin
                rdata_r <= {24'h000000, rd_val};
                rresp_r <= ra_ok ? smbext_pkg::RESP_OKAY : smbext_pkg::RESP_SLVERR;
            end
        end
    end

    // ========================================
    // Glitch filter, one lane per bus line
    wire  [1:0]    line_in = {sda_in, scl_in};
    logic [1:0]    filt_r;
    logic [CW-1:0] fcnt_r [2];
    logic [CW-1:0] fcnt_nxt [2];
    logic [1:0]    accept;

    for (genvar i = 0; i < 2; i++) begin : g_filt
        wire diff = line_in[i] != filt_r[i];
        // Each cycle spans STEP filter periods
        assign fcnt_nxt[i] = diff ? fcnt_r[i] + STEP : '0;
        assign accept[i]   = (flt_r == '0) || (diff && fcnt_nxt[i] > CW'(flt_r));
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                filt_r[i] <= 1'b1;
                fcnt_r[i] <= '0;
            end else begin
                filt_r[i] <= accept[i] ? line_in[i] : filt_r[i];
                fcnt_r[i] <= accept[i] ? '0 : fcnt_nxt[i];
            end
        end
    end
    assign scl_filt_r = filt_r[0];
    assign sda_filt_r = filt_r[1];

    // ========================================
    // Timeout counters
    logic [5:0]  presc_r;
    logic [15:0] low_cnt_r, hi_cnt_r;
    logic [1:0]  lvl_q_r;
    logic        low_hit_q_r, hl_q_r;

    wire tick      = timeout_clk_sel | (presc_r == smbext_pkg::PRESC_LAST);
    wire [15:0] hi_thr = lt_val >> smbext_pkg::HI_SHIFT;
    wire low_hit   = !scl_filt_r && (lt_val != 16'h0000) && (low_cnt_r >= lt_val);
    wire both_hi   = scl_filt_r & sda_filt_r;
    wire free_now  = both_hi && lvl_q_r == filt_r && hi_cnt_r > hi_thr;
    wire hl_now    = scl_filt_r && !sda_filt_r && lvl_q_r == filt_r && hi_cnt_r > hi_thr;
    wire low_evt   = low_hit & ~low_hit_q_r;
    wire hl_evt    = hl_now & ~hl_q_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_r     <= '0;
            low_cnt_r   <= '0;
            hi_cnt_r    <= '0;
            lvl_q_r     <= 2'b11;
            low_hit_q_r <= 1'b0;
            hl_q_r      <= 1'b0;
            bus_free_r  <= 1'b0;
        end else begin
            presc_r     <= presc_r + 6'h01;
            lvl_q_r     <= filt_r;
            low_hit_q_r <= low_hit;
            hl_q_r      <= hl_now;
            bus_free_r  <= free_now;
            if (scl_filt_r)
                low_cnt_r <= '0;
            else if (tick && low_cnt_r != 16'hffff)
                low_cnt_r <= low_cnt_r + 16'h0001;
            if (lvl_q_r != filt_r || !scl_filt_r)
                hi_cnt_r <= '0;
            else if (tick && hi_cnt_r != 16'hffff)
                hi_cnt_r <= hi_cnt_r + 16'h0001;
        end
    end

    // ========================================
    // Sticky flags, set wins over clear
    wire clr_scl_low_timeout_flag = wr_smb & wb[smbext_pkg::B_SCL_LOW_TIMEOUT_FLAG];
    wire clr_hlf  = wr_smb & wb[smbext_pkg::B_HLF];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_low_timeout_flag_r <= 1'b0;
            hlf_r  <= 1'b0;
        end else begin
            scl_low_timeout_flag_r <= low_evt | (scl_low_timeout_flag_r & ~clr_scl_low_timeout_flag);
            hlf_r  <= hl_evt | (hlf_r & ~clr_hlf);
        end
    end

    // ========================================
    // Acknowledge control
    logic ack_strobe_r, ack_nack_r;
    wire  ack_fast_go = fast_en & ack_pend_r & wr_ack;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_pend_r   <= 1'b0;
            ack_strobe_r <= 1'b0;
            ack_nack_r   <= 1'b0;
        end else begin
            ack_pend_r <= (fast_en & rx_byte_done) | (ack_pend_r & ~wr_ack & fast_en);
            if (!fast_en && rx_byte_done) begin
                ack_strobe_r <= 1'b1;
                ack_nack_r   <= ack_bit_r;
            end else if (ack_fast_go) begin
                ack_strobe_r <= 1'b1;
                ack_nack_r   <= wb[0];
            end else begin
                ack_strobe_r <= 1'b0;
            end
        end
    end

    // ========================================
    // Address matching
    logic alert_match_r, second_match_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alert_match_r  <= 1'b0;
            second_match_r <= 1'b0;
        end else begin
            alert_match_r  <= addr_valid && alert_en && addr_byte[7:1] == smbext_pkg::ALERT_ADDR;
            second_match_r <= addr_valid && sec_en && addr_byte[7:1] == addr2_r[7:1];
        end
    end

    // ========================================
    // Interrupts
    logic irq_r;
    wire [smbext_pkg::IRQ_W-1:0] iclr = wr_istat ? wb[smbext_pkg::IRQ_W-1:0] : '0;
    wire [smbext_pkg::IRQ_W-1:0] istat_nxt = ievt | (istat_r & ~iclr);

    always_comb begin
        ievt = '0;
        ievt[smbext_pkg::I_LOW]   = low_evt;
        ievt[smbext_pkg::I_HL]    = hl_evt & hl_ie;
        ievt[smbext_pkg::I_ACK]   = fast_en & rx_byte_done;
        ievt[smbext_pkg::I_MATCH] = alert_match_r | second_match_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_r <= '0;
            irq_r   <= 1'b0;
        end else begin
            istat_r <= istat_nxt;
            irq_r   <= |(istat_nxt & imask_r);
        end
    end

    assign awready      = awready_r;
    assign wready       = wready_r;
    assign bvalid       = bvalid_r;
    assign bresp        = bresp_r;
    assign arready      = arready_r;
    assign rvalid       = rvalid_r;
    assign rdata        = rdata_r;
    assign rresp        = rresp_r;
    assign scl_filt     = scl_filt_r;
    assign sda_filt     = sda_filt_r;
    assign ack_strobe   = ack_strobe_r;
    assign ack_nack     = ack_nack_r;
    assign alert_match  = alert_match_r;
    assign second_match = second_match_r;
    assign bus_idle     = bus_free_r;
    assign irq          = irq_r;

    // ========================================
    // Checks
    AST_BYPASS: assert property (@(posedge aclk) disable iff (!aresetn)
        flt_r == '0 |=> scl_filt_r == $past(scl_in))
        else $error("bypass filter not transparent");
    AST_GLITCH: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(scl_filt_r) && $past(flt_r) != '0 |-> $past(fcnt_nxt[0]) > CW'($past(flt_r)))
        else $error("filter passed a short pulse");
    AST_SLOW_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
        !fast_en && rx_byte_done |=> ack_strobe_r && ack_nack_r == $past(ack_bit_r))
        else $error("stored ack not applied");
    AST_FAST_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
        fast_en && ack_pend_r && wr_ack |=> ack_strobe_r && ack_nack_r == $past(wb[0]))
        else $error("fast ack value wrong");
    AST_ALERT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !alert_en |=> !alert_match_r)
        else $error("alert match while disabled");
    AST_SECOND: assert property (@(posedge aclk) disable iff (!aresetn)
        addr_valid && sec_en && addr_byte[7:1] == addr2_r[7:1] |=> second_match_r)
        else $error("second address missed");
    AST_PRESC: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !timeout_clk_sel ##1 !timeout_clk_sel |-> !tick)
        else $error("slow tick too fast");
    AST_LOW_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        low_evt |=> scl_low_timeout_flag_r && !$past(scl_filt_r))
        else $error("low timeout flag not set");
    AST_LOW_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        lt_val == 16'h0000 && !scl_low_timeout_flag_r |=> !scl_low_timeout_flag_r)
        else $error("low timeout while disabled");
    AST_FREE: assert property (@(posedge aclk) disable iff (!aresetn)
        bus_free_r |-> $past(scl_filt_r) && $past(sda_filt_r))
        else $error("bus free without idle lines");
    AST_HL_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        hl_evt |=> hlf_r)
        else $error("high low flag not set");
endmodule
`default_nettype wire

/* bench/smbext_bus_model.sv */
// Far-side bus model driving the SCL and SDA levels
`timescale 1ns/1ps
`default_nettype none
module smbext_bus_model (
    input  wire logic aclk,
    output var logic  scl_line,
    output var logic  sda_line
);
    // ========================================
    // Lines idle high through the pull-ups
    initial begin
        scl_line = 1'b1;
        sda_line = 1'b1;
    end
    // Holds both lines for n cycles
    task automatic drive(input logic s, input logic d, input int n);
        scl_line <= s;
        sda_line <= d;
        repeat (n) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* bench/smbext_top_test.sv */
// Testbench for the SMBus extension block
`timescale 1ns/1ps
`default_nettype none
module smbext_top_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, scl_in, sda_in;
    logic        scl_filt, sda_filt, rx_byte_done, addr_valid, ack_strobe, ack_nack;
    logic        alert_match, second_match, bus_idle, irq, last_nack;
    logic [7:0]  awaddr, araddr, addr_byte;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          err_total = 0, total_checks = 0, n_ack = 0, n_alert = 0, n_second = 0;
    int          n_low = 0, low_mark = 0;

    smbext_top #(.FLT_W(4), .DOUBLE_RATE(1'b0), .AW(8)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_in(scl_in),
        .sda_in(sda_in), .scl_filt(scl_filt), .sda_filt(sda_filt), .rx_byte_done(rx_byte_done),
        .addr_valid(addr_valid), .addr_byte(addr_byte), .ack_strobe(ack_strobe),
        .ack_nack(ack_nack), .alert_match(alert_match), .second_match(second_match),
        .bus_idle(bus_idle), .irq(irq)
    );
    smbext_bus_model u_bus (.aclk(aclk), .scl_line(scl_in), .sda_line(sda_in));

    // ========================================
    // Clock and pulse monitor
    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (ack_strobe === 1'b1) begin
            n_ack     <= n_ack + 1;
            last_nack <= ack_nack;
        end
        if (alert_match === 1'b1) n_alert <= n_alert + 1;
        if (second_match === 1'b1) n_second <= n_second + 1;
        if (sda_filt === 1'b0) n_low <= n_low + 1;
    end

    // ========================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
        int n;
        n = 0;
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h000000, d};
        wstrb   <= 4'h1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        chk({30'h0, bresp}, {30'h0, er});
        if (n >= 50) err_total++;
        repeat (2) @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk = 32'hffffffff,
                      input logic [1:0] er = 2'b00);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        chk(rdata & msk, exp);
        chk({30'h0, rresp}, {30'h0, er});
        if (n >= 50) err_total++;
    endtask
    task automatic rx_pulse;
        rx_byte_done <= 1'b1;
        @(posedge aclk);
        rx_byte_done <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic addr_pulse(input logic [7:0] b);
        addr_byte  <= b;
        addr_valid <= 1'b1;
        @(posedge aclk);
        addr_valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // ========================================
    // Tests
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; bready = 1'b1; rready = 1'b1;
        rx_byte_done = 1'b0; addr_valid = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        wstrb = 4'h0; addr_byte = 8'h00; last_nack = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h20, 32'h3, 32'h3);
        rd(8'h24, 32'h0, 32'hffffffff, 2'b10);
        wr(8'h24, 8'hff, 2'b10);
        wr(8'h08, 8'ha5);
        rd(8'h08, 32'ha4);
        addr_pulse(8'ha4);
        addr_pulse(8'h18);
        wr(8'h04, 8'h60);
        addr_pulse(8'ha5);
        addr_pulse(8'h18);
        addr_pulse(8'h1a);
        chk(32'(n_second), 32'h1);
        chk(32'(n_alert), 32'h1);
        wr(8'h1c, 8'h01);
        rx_pulse;
        chk(32'(n_ack), 32'h1);
        chk({31'h0, last_nack}, 32'h1);
        wr(8'h04, 8'h80);
        rx_pulse;
        chk(32'(n_ack), 32'h1);
        wr(8'h1c, 8'h00);
        chk(32'(n_ack), 32'h2);
        chk({31'h0, last_nack}, 32'h0);
        wr(8'h00, 8'h03);
        low_mark = n_low;
        u_bus.drive(1'b1, 1'b0, 3);
        u_bus.drive(1'b1, 1'b1, 10);
        chk(32'(n_low - low_mark), 32'h0);
        u_bus.drive(1'b1, 1'b0, 4);
        u_bus.drive(1'b1, 1'b1, 10);
        chk(32'(n_low - low_mark), 32'h4);
        wr(8'h00, 8'h00);
        low_mark = n_low;
        u_bus.drive(1'b1, 1'b0, 1);
        u_bus.drive(1'b1, 1'b1, 4);
        chk(32'(n_low - low_mark), 32'h1);
        wr(8'h04, 8'h10);
        u_bus.drive(1'b0, 1'b1, 40);
        chk({31'h0, scl_filt}, 32'h0);
        u_bus.drive(1'b1, 1'b1, 4);
        rd(8'h04, 32'h0, 32'h8);
        wr(8'h10, 8'h05);
        u_bus.drive(1'b0, 1'b1, 3);
        u_bus.drive(1'b1, 1'b1, 4);
        rd(8'h04, 32'h0, 32'h8);
        u_bus.drive(1'b0, 1'b1, 10);
        u_bus.drive(1'b1, 1'b1, 4);
        rd(8'h04, 32'h8, 32'h8);
        wr(8'h04, 8'h08);
        rd(8'h04, 32'h0, 32'h8);
        u_bus.drive(1'b0, 1'b1, 200);
        rd(8'h04, 32'h0, 32'h8);
        u_bus.drive(1'b0, 1'b1, 200);
        rd(8'h04, 32'h8, 32'h8);
        u_bus.drive(1'b1, 1'b1, 150);
        rd(8'h04, 32'h4, 32'h4);
        chk({31'h0, bus_idle}, 32'h1);
        u_bus.drive(1'b0, 1'b1, 3);
        rd(8'h04, 32'h0, 32'h4);
        chk({31'h0, bus_idle}, 32'h0);
        wr(8'h10, 8'h00);
        wr(8'h0c, 8'h01);
        wr(8'h04, 8'h18);
        u_bus.drive(1'b0, 1'b1, 200);
        rd(8'h04, 32'h0, 32'h8);
        u_bus.drive(1'b0, 1'b1, 100);
        rd(8'h04, 32'h8, 32'h8);
        u_bus.drive(1'b1, 1'b1, 5);
        wr(8'h04, 8'h1b);
        wr(8'h14, 8'h0f);
        wr(8'h18, 8'h02);
        u_bus.drive(1'b1, 1'b0, 10);
        u_bus.drive(1'b1, 1'b1, 2);
        rd(8'h04, 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(8'h04, 8'h13);
        rd(8'h04, 32'h0, 32'h2);
        wr(8'h14, 8'h02);
        chk({31'h0, irq}, 32'h0);
        wr(8'h04, 8'h10);
        u_bus.drive(1'b1, 1'b0, 10);
        u_bus.drive(1'b1, 1'b1, 2);
        rd(8'h14, 32'h0, 32'h2);
        chk({31'h0, irq}, 32'h0);
        report_and_stop;
    end

    // ========================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        report_and_stop;
    end
endmodule
`default_nettype wire
